// >>> hdl/bsci_pkg.sv
package bsci_pkg;

    // sizes of the result and of the calibration store
    localparam int RESULT_W = 24;
    localparam int CAL_WORDS = 8;
    localparam int CAL_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int BYTE_W = 8;

    // command byte layout
    localparam logic [7:0] CMD_RESET = 8'h1e;
    localparam logic [7:0] CMD_ADC_READ = 8'h00;
    localparam logic [7:0] CONV_PATTERN = 8'h40;
    localparam logic [7:0] CONV_MASK = 8'he1;
    localparam logic [7:0] PROM_PATTERN = 8'ha0;
    localparam logic [7:0] PROM_MASK = 8'hf1;
    localparam int CHAN_BIT = 4;
    localparam int FIELD_LSB = 1;
    localparam logic [2:0] RATIO_MAX = 3'h4;

    // reply lengths in bytes
    localparam logic [1:0] ADC_REPLY_BYTES = 2'h3;
    localparam logic [1:0] PROM_REPLY_BYTES = 2'h2;

    // upper six bits of the two-wire address, low bit from the strap
    localparam logic [5:0] I2C_ADDR_HI = 6'h3b;

    // cycles after reset release before the straps are trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // conversion length for the lowest ratio, scaled by 2**ratio
    localparam int CONV_BASE_CYCLES = 64;

    typedef enum logic [2:0] {
        BSCI_CK_NONE,
        BSCI_CK_RESET,
        BSCI_CK_CONV,
        BSCI_CK_ADC,
        BSCI_CK_PROM
    } bsci_cmd_kind_t;

    typedef struct packed {
        logic [RESULT_W-1:0] pressure;
        logic [RESULT_W-1:0] temperature;
    } bsci_sample_t;

    typedef logic [CAL_WORDS-1:0][CAL_W-1:0] bsci_calib_t;

    // synchronised pin group
    typedef struct packed {
        logic sclk;
        logic din;
        logic sel_n;
        logic proto_sel;
    } bsci_pins_t;

    // only the four documented command forms are recognised
    function automatic bsci_cmd_kind_t bsci_decode(input logic [7:0] c);
        bsci_cmd_kind_t k;
        k = BSCI_CK_NONE;
        if (c == CMD_RESET) begin
            k = BSCI_CK_RESET;
        end else if (c == CMD_ADC_READ) begin
            k = BSCI_CK_ADC;
        end else if ((c & CONV_MASK) == CONV_PATTERN &&
                     c[FIELD_LSB+:3] <= RATIO_MAX) begin
            k = BSCI_CK_CONV;
        end else if ((c & PROM_MASK) == PROM_PATTERN) begin
            k = BSCI_CK_PROM;
        end
        return k;
    endfunction

endpackage

// >>> hdl/bsci_fifo.sv
`timescale 1ns/1ns
module bsci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // full and empty come straight from the occupancy count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready && !clear;
    assign pop = out_valid && out_ready && !clear;

    // storage array has no reset; only valid entries are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers wrap at the depth, clear drops everything stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clear) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

// >>> hdl/bsci_top.sv
`timescale 1ns/1ns
module bsci_top #(
    parameter int CONV_BASE = bsci_pkg::CONV_BASE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic protocol_select_strap,
    input wire logic select_n_strap,
    input wire logic serial_clk,
    input wire logic serial_in_line,
    input wire bsci_pkg::bsci_sample_t sensor_in,
    input wire bsci_pkg::bsci_calib_t factory_calib,
    output logic serial_out_line,
    output logic sda_out,
    output logic sda_oe,
    output logic conversion_busy,
    output logic result_ready,
    output logic i2c_mode
);
    typedef enum logic [6:0] {
        BSCI_I_IDLE = 7'b0000001,
        BSCI_I_ADDR = 7'b0000010,
        BSCI_I_AACK = 7'b0000100,
        BSCI_I_WR = 7'b0001000,
        BSCI_I_WACK = 7'b0010000,
        BSCI_I_RD = 7'b0100000,
        BSCI_I_RACK = 7'b1000000
    } bsci_i2c_state_t;

    bsci_pkg::bsci_pins_t pin_raw;
    bsci_pkg::bsci_pins_t meta_q;
    bsci_pkg::bsci_pins_t sync_q;
    bsci_pkg::bsci_pins_t prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic i2c_start;
    logic i2c_stop;
    logic [1:0] settle_q;
    logic mode_valid_q;
    logic spi_en;
    logic i2c_en;
    logic [2:0] spi_cnt_q;
    logic [7:0] spi_rx_q;
    logic [7:0] spi_tx_q;
    logic spi_pop;
    bsci_i2c_state_t ist_q;
    logic [2:0] i_cnt_q;
    logic [7:0] i_rx_q;
    logic [7:0] i_tx_q;
    logic i_ph_q;
    logic i_rw_q;
    logic i_nack_q;
    logic i2c_load;
    logic [7:0] rx_byte;
    logic cmd_stb;
    bsci_pkg::bsci_cmd_kind_t kind;
    logic accept;
    logic [2:0] field;
    logic [7:0] head;
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] out_byte;
    logic [15:0] conv_cnt_q;
    logic chan_q;
    logic corrupt_q;
    logic corrupt_now;
    logic conv_end;
    logic [bsci_pkg::RESULT_W-1:0] result_q;
    logic [bsci_pkg::RESULT_W-1:0] fresh;
    logic [bsci_pkg::CAL_W-1:0] calib_q [bsci_pkg::CAL_WORDS];
    logic [bsci_pkg::RESULT_W-1:0] reply_q;
    logic [1:0] left_q;

    assign pin_raw = {serial_clk, serial_in_line, select_n_strap,
                      protocol_select_strap};

    // two-stage synchroniser; prev_q only ever sees the second stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sclk_rise = sync_q.sclk && !prev_q.sclk;
    assign sclk_fall = !sync_q.sclk && prev_q.sclk;
    assign i2c_start = sync_q.sclk && prev_q.sclk && prev_q.din && !sync_q.din;
    assign i2c_stop = sync_q.sclk && prev_q.sclk && !prev_q.din && sync_q.din;

    // the protocol strap is caught once after the synchroniser has filled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            settle_q <= '0;
            mode_valid_q <= 1'b0;
            i2c_mode <= 1'b0;
        end else if (!mode_valid_q) begin
            if (settle_q == bsci_pkg::STRAP_SETTLE) begin
                mode_valid_q <= 1'b1;
                i2c_mode <= !sync_q.proto_sel;
            end else begin
                settle_q <= settle_q + 1'b1;
            end
        end
    end

    // only one port is ever live
    assign spi_en = mode_valid_q && !i2c_mode;
    assign i2c_en = mode_valid_q && i2c_mode;

    // an empty buffer sends zeros rather than a stale entry
    assign out_byte = fifo_valid ? head : 8'h00;

    // four-wire port: bits counted on rising edges, so the idle level
    // of the clock does not matter
    assign spi_pop = spi_en && !sync_q.sel_n && sclk_fall &&
                     spi_cnt_q == 3'h0;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spi_cnt_q <= '0;
            spi_rx_q <= '0;
            spi_tx_q <= '0;
            serial_out_line <= 1'b0;
        end else if (!spi_en || sync_q.sel_n) begin
            spi_cnt_q <= '0;
            spi_tx_q <= '0;
            serial_out_line <= 1'b0;
        end else if (sclk_rise) begin
            spi_rx_q <= {spi_rx_q[6:0], sync_q.din};
            spi_cnt_q <= spi_cnt_q + 1'b1;
        end else if (spi_pop) begin
            serial_out_line <= out_byte[7];
            spi_tx_q <= {out_byte[6:0], 1'b0};
        end else if (sclk_fall) begin
            serial_out_line <= spi_tx_q[7];
            spi_tx_q <= {spi_tx_q[6:0], 1'b0};
        end
    end

    // a byte is loaded onto the two-wire line at the fall after an ack
    assign i2c_load = i2c_en && !i2c_start && !i2c_stop && sclk_fall &&
                      i_ph_q && ((ist_q == BSCI_I_AACK && i_rw_q) ||
                                 ist_q == BSCI_I_RACK);

    // two-wire port; sda changes only while the clock is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ist_q <= BSCI_I_IDLE;
            i_cnt_q <= '0;
            i_rx_q <= '0;
            i_tx_q <= '0;
            i_ph_q <= 1'b0;
            i_rw_q <= 1'b0;
            i_nack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (!i2c_en || i2c_stop) begin
            ist_q <= BSCI_I_IDLE;
            sda_oe <= 1'b0;
        end else if (i2c_start) begin
            ist_q <= BSCI_I_ADDR;
            i_cnt_q <= '0;
            sda_oe <= 1'b0;
        end else if (i2c_load) begin
            ist_q <= BSCI_I_RD;
            i_cnt_q <= '0;
            sda_oe <= !out_byte[7];
            i_tx_q <= {out_byte[6:0], 1'b0};
        end else begin
            unique case (ist_q)
                BSCI_I_IDLE: begin
                    sda_oe <= 1'b0;
                end
                BSCI_I_ADDR, BSCI_I_WR: begin
                    if (sclk_rise) begin
                        i_rx_q <= {i_rx_q[6:0], sync_q.din};
                        i_cnt_q <= i_cnt_q + 1'b1;
                        i_ph_q <= 1'b0;
                        if (i_cnt_q == 3'h7 && ist_q == BSCI_I_WR) begin
                            ist_q <= BSCI_I_WACK;
                        end else if (i_cnt_q == 3'h7) begin
                            // strap high answers 0x76, low 0x77
                            if (i_rx_q[6:0] ==
                                {bsci_pkg::I2C_ADDR_HI, !sync_q.sel_n}) begin
                                ist_q <= BSCI_I_AACK;
                                i_rw_q <= sync_q.din;
                            end else begin
                                ist_q <= BSCI_I_IDLE;
                            end
                        end
                    end
                end
                BSCI_I_AACK, BSCI_I_WACK: begin
                    if (sclk_fall && !i_ph_q) begin
                        sda_oe <= 1'b1;
                        i_ph_q <= 1'b1;
                    end else if (sclk_fall) begin
                        sda_oe <= 1'b0;
                        i_cnt_q <= '0;
                        ist_q <= BSCI_I_WR;
                    end
                end
                BSCI_I_RD: begin
                    if (sclk_rise) begin
                        i_cnt_q <= i_cnt_q + 1'b1;
                        if (i_cnt_q == 3'h7) begin
                            ist_q <= BSCI_I_RACK;
                            i_ph_q <= 1'b0;
                        end
                    end else if (sclk_fall) begin
                        sda_oe <= !i_tx_q[7];
                        i_tx_q <= {i_tx_q[6:0], 1'b0};
                    end
                end
                BSCI_I_RACK: begin
                    // release, then sample the master's ack; a nack returns to idle
                    if (sclk_fall && !i_ph_q) begin
                        sda_oe <= 1'b0;
                        i_ph_q <= 1'b1;
                    end else if (sclk_rise && i_ph_q) begin
                        i_nack_q <= sync_q.din;
                        if (sync_q.din) begin
                            ist_q <= BSCI_I_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // command bytes from either port reach one decoder
    assign rx_byte = i2c_en ? {i_rx_q[6:0], sync_q.din}
                            : {spi_rx_q[6:0], sync_q.din};
    assign cmd_stb = sclk_rise && !i2c_start && !i2c_stop &&
                     ((spi_en && !sync_q.sel_n && spi_cnt_q == 3'h7) ||
                      (i2c_en && ist_q == BSCI_I_WR && i_cnt_q == 3'h7));
    assign kind = bsci_pkg::bsci_decode(rx_byte);
    assign accept = cmd_stb && kind != bsci_pkg::BSCI_CK_NONE;
    assign field = rx_byte[bsci_pkg::FIELD_LSB+:3];

    // a read that races the end of conversion still corrupts it
    assign corrupt_now = corrupt_q ||
                         (accept && kind == bsci_pkg::BSCI_CK_ADC);
    assign conv_end = conversion_busy && conv_cnt_q == '0;
    assign fresh = chan_q ? sensor_in.temperature : sensor_in.pressure;

    // conversion timer runs on regardless of select or other port traffic; only a reset command stops it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conversion_busy <= 1'b0;
            conv_cnt_q <= '0;
            chan_q <= 1'b0;
            corrupt_q <= 1'b0;
            result_q <= '0;
            result_ready <= 1'b0;
        end else if (accept && kind == bsci_pkg::BSCI_CK_RESET) begin
            conversion_busy <= 1'b0;
            corrupt_q <= 1'b0;
            result_q <= '0;
            result_ready <= 1'b0;
        end else begin
            if (conv_end) begin
                conversion_busy <= 1'b0;
                result_q <= corrupt_now ? ~fresh : fresh;
                result_ready <= 1'b1;
                corrupt_q <= 1'b0;
            end else if (conversion_busy) begin
                conv_cnt_q <= conv_cnt_q - 1'b1;
                corrupt_q <= corrupt_now;
            end
            if (accept && kind == bsci_pkg::BSCI_CK_CONV) begin
                if (conversion_busy && !conv_end) begin
                    corrupt_q <= 1'b1;
                end else begin
                    conversion_busy <= 1'b1;
                    chan_q <= rx_byte[bsci_pkg::CHAN_BIT];
                    conv_cnt_q <= 16'(CONV_BASE << field) - 1'b1;
                    result_ready <= 1'b0;
                end
            end else if (accept && kind == bsci_pkg::BSCI_CK_ADC &&
                         !conv_end) begin
                result_ready <= 1'b0;
            end
        end
    end

    // calibration register, cleared by rst and refilled from the factory image on the reset command
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < bsci_pkg::CAL_WORDS; i++) begin
                calib_q[i] <= '0;
            end
        end else if (accept && kind == bsci_pkg::BSCI_CK_RESET) begin
            for (int i = 0; i < bsci_pkg::CAL_WORDS; i++) begin
                calib_q[i] <= factory_calib[i];
            end
        end
    end

    // reply bytes go into the buffer msb first; a stalled buffer holds
    // the sequencer, and every accepted command drops a stale reply
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reply_q <= '0;
            left_q <= '0;
        end else if (accept) begin
            unique case (kind)
                bsci_pkg::BSCI_CK_ADC: begin
                    left_q <= bsci_pkg::ADC_REPLY_BYTES;
                    reply_q <= (conversion_busy || !result_ready) ?
                               '0 : result_q;
                end
                bsci_pkg::BSCI_CK_PROM: begin
                    left_q <= bsci_pkg::PROM_REPLY_BYTES;
                    reply_q <= {calib_q[field], 8'h00};
                end
                default: begin
                    left_q <= '0;
                    reply_q <= '0;
                end
            endcase
        end else if (left_q != '0 && fifo_ready) begin
            reply_q <= {reply_q[15:0], 8'h00};
            left_q <= left_q - 1'b1;
        end
    end

    // sda is open drain: the driven level is always low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    bsci_fifo #(
        .WIDTH(bsci_pkg::BYTE_W),
        .DEPTH(bsci_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .clear(accept),
        .in_valid(left_q != '0),
        .in_ready(fifo_ready),
        .in_data(reply_q[23:16]),
        .out_valid(fifo_valid),
        .out_ready(spi_pop || i2c_load),
        .out_data(head)
    );

endmodule

// >>> testbench/bsci_top_properties.sv
`timescale 1ns/1ns
module bsci_top_checker #(
    parameter int CONV_BASE = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic protocol_select_strap,
    input wire logic select_n_strap,
    input wire logic serial_out_line,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic conversion_busy,
    input wire logic result_ready,
    input wire logic i2c_mode
);
    localparam int BUSY_MAX = (CONV_BASE << 4) + 4;
    logic [15:0] busy_cnt_q;

    // counts the running conversion; a delay range cannot reach 1028
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= conversion_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_sel_quiet;
        (!i2c_mode && select_n_strap)[*6] |-> !serial_out_line;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet)
        else $error("data out driven while deselected");

    property p_i2c_quiet;
        i2c_mode |-> !serial_out_line && !sda_out;
    endproperty
    a_i2c_quiet: assert property (p_i2c_quiet)
        else $error("four-wire output active in two-wire mode");

    property p_spi_no_ack;
        !i2c_mode && protocol_select_strap |-> !sda_oe;
    endproperty
    a_spi_no_ack: assert property (p_spi_no_ack)
        else $error("data pin pulled in four-wire mode");

    property p_ready_cause;
        $rose(result_ready) |-> $past(conversion_busy) ||
            $past(conversion_busy, 2);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("result offered without a conversion");

    property p_busy_max;
        busy_cnt_q <= BUSY_MAX;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("conversion runs too long");

    property p_busy_min;
        $fell(conversion_busy) && result_ready |-> busy_cnt_q >= CONV_BASE;
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("conversion ended too early");

    property p_busy_end;
        $fell(conversion_busy) && select_n_strap && !i2c_mode |->
            result_ready;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("conversion ended without a result");

    property p_reset_quiet;
        $fell(rst) |-> !conversion_busy && !result_ready && !sda_oe &&
            !i2c_mode && !serial_out_line;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared by reset");

    property p_mode_latch;
        $fell(rst) ##0 (!protocol_select_strap)[*8] |-> i2c_mode;
    endproperty
    a_mode_latch: assert property (p_mode_latch)
        else $error("two-wire strap not latched");
endmodule

bind bsci_top bsci_top_checker #(.CONV_BASE(CONV_BASE)) u_chk (
    .core_clk(core_clk), .rst(rst),
    .protocol_select_strap(protocol_select_strap),
    .select_n_strap(select_n_strap), .serial_out_line(serial_out_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .conversion_busy(conversion_busy),
    .result_ready(result_ready), .i2c_mode(i2c_mode)
);

// >>> testbench/bsci_link_master.sv
`timescale 1ns/1ns
module bsci_link_master (
    output logic link_clk,
    output logic link_dout,
    output logic sel_n,
    input wire logic link_din
);
    logic mode3 = 1'b0;

    // idle bus: clock still, deselected
    initial begin
        link_clk = 1'b0;
        link_dout = 1'b1;
        sel_n = 1'b1;
    end

    // command byte then dummy 0xff bytes, which decode to nothing
    task automatic spi_frame(input logic [7:0] cmd, input int nrd,
                             output logic [23:0] rd);
        logic [7:0] tx;
        rd = 24'h000000;
        link_clk = mode3;
        #80;
        sel_n = 1'b0;
        #80;
        for (int b = 0; b <= nrd; b++) begin
            tx = (b == 0) ? cmd : 8'hff;
            for (int i = 7; i >= 0; i--) begin
                link_clk = 1'b0;
                link_dout = tx[i];
                #80;
                if (b > 0) rd = {rd[22:0], link_din};
                link_clk = 1'b1;
                #80;
            end
        end
        link_clk = mode3;
        #80;
        sel_n = 1'b1;
        link_dout = ~link_dout; // no stale level once released
    endtask

    // start, address byte, then nrd bytes, each a copy of wb or a read byte,
    // each with its acknowledge slot, then stop
    task automatic i2c_msg(input logic [7:0] ab, input logic [7:0] wb,
                           input int nrd, output logic ack,
                           output logic [23:0] rd);
        rd = 24'h000000;
        link_dout = 1'b1;
        link_clk = 1'b1;
        #80;
        link_dout = 1'b0;
        #80;
        for (int b = 0; b <= nrd; b++) begin
            for (int i = 7; i >= 0; i--) begin
                link_clk = 1'b0;
                link_dout = (b == 0) ? ab[i] : (ab[0] | wb[i]);
                #80;
                if (b > 0) rd = {rd[22:0], link_din};
                link_clk = 1'b1;
                #80;
            end
            // the master acks every read byte but the last
            link_clk = 1'b0;
            link_dout = !ab[0] || b == 0 || b == nrd;
            #80;
            link_clk = 1'b1;
            if (b == 0) ack = ~link_din; // low means acknowledged
            #80;
        end
        link_clk = 1'b0;
        #80;
        link_dout = 1'b0;
        #80;
        link_clk = 1'b1;
        #80;
        link_dout = 1'b1;
        #80;
    endtask
endmodule

// >>> testbench/bsci_top_tb.sv
`timescale 1ns/1ns
module bsci_top_tb;
    localparam int CB = 16;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic spi_strap = 1'b1;
    logic addr_strap = 1'b0;
    logic link_clk, link_dout, sel_n, sda_wire, miso, ack;
    logic serial_out_line, sda_out, sda_oe, busy, ready, i2c_mode;
    bsci_pkg::bsci_sample_t sensor;
    bsci_pkg::bsci_calib_t calib;
    logic [23:0] rd;
    logic [7:0] cmd;
    int failures = 0;
    int n_compared = 0;
    int busy_n = 0;

    always #4 core_clk = ~core_clk;
    // open-drain data line with pull-up; both parties share it
    assign sda_wire = link_dout & ~sda_oe;
    assign miso = spi_strap ? serial_out_line : sda_wire;
    // counts cycles spent converting
    always @(posedge core_clk) if (busy === 1'b1) busy_n++;

    bsci_link_master master (.link_clk(link_clk), .link_dout(link_dout),
        .sel_n(sel_n), .link_din(miso));
    bsci_top #(.CONV_BASE(CB)) dut (.core_clk(core_clk), .rst(rst),
        .protocol_select_strap(spi_strap),
        .select_n_strap(spi_strap ? sel_n : addr_strap),
        .serial_clk(link_clk), .serial_in_line(sda_wire),
        .sensor_in(sensor), .factory_calib(calib),
        .serial_out_line(serial_out_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .conversion_busy(busy), .result_ready(ready),
        .i2c_mode(i2c_mode));

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask

    // a hung handshake ends the run here
    initial begin
        #600000;
        failures++;
        $display("wrong value watchdog expected done seen timeout");
        final_report();
    end

    initial begin
        sensor = {24'h9a3c51, 24'h3c5a96};
        for (int i = 0; i < 8; i++) calib[i] = 16'hc3a0 + 16'h0b17 * 16'(i);
        do_reset();
        check("mode", 24'h000000, 24'(i2c_mode));
        master.spi_frame(8'ha6, 2, rd);
        check("word before reset", 24'h000000, rd);
        master.spi_frame(bsci_pkg::CMD_RESET, 0, rd);
        for (int w = 0; w < 8; w++) begin
            master.mode3 = w[0];
            master.spi_frame({4'ha, w[2:0], 1'b0}, 3, rd);
            check("calib word", {calib[w], 8'h00}, rd);
        end
        $display("test calibration done");
        master.spi_frame(8'h00, 3, rd);
        check("read without conversion", 24'h000000, rd);
        for (int ch = 0; ch < 2; ch++) begin
            for (int r = 0; r < 5; r++) begin
                master.mode3 = r[0];
                cmd = {3'h2, ch[0], r[2:0], 1'b0};
                busy_n = 0;
                master.spi_frame(cmd, 0, rd);
                master.spi_frame(r[0] ? 8'h5a : 8'h41, 0, rd);
                for (int t = 0; t < 400 && ready !== 1'b1; t++) begin
                    @(negedge core_clk);
                end
                check("ready", 24'h000001, 24'(ready));
                n_compared++;
                if (busy_n < (CB << r) || busy_n > (CB << r) + 2) begin
                    failures++;
                    $display("wrong value busy cycles expected %0d seen %0d",
                        (CB << r) + 1, busy_n);
                end
                master.spi_frame(8'h00, 3, rd);
                check("result", ch ? sensor.temperature : sensor.pressure,
                    rd);
                master.spi_frame(8'h00, 3, rd);
                check("repeated read", 24'h000000, rd);
            end
        end
        $display("test conversions done");
        master.spi_frame(8'h48, 0, rd);
        master.spi_frame(8'h00, 3, rd);
        check("read while busy", 24'h000000, rd);
        master.spi_frame(8'h00, 3, rd);
        check("corrupted result", ~sensor.pressure, rd);
        $display("test early read done");
        for (int s = 0; s < 4; s++) begin
            spi_strap = 1'b0;
            addr_strap = s[1];
            do_reset();
            check("two-wire mode", 24'h000001, 24'(i2c_mode));
            master.i2c_msg({6'h3b, s[0], 1'b0}, 8'h00, 0, ack, rd);
            check("address ack", 24'(s[0] != s[1]), 24'(ack));
        end
        $display("test address done");
        // strap is high now, so the port answers at 0x76
        master.i2c_msg(8'hec, bsci_pkg::CMD_RESET, 1, ack, rd);
        master.i2c_msg(8'hec, 8'ha6, 1, ack, rd);
        master.i2c_msg(8'hed, 8'h00, 2, ack, rd);
        check("two-wire calib word", {8'h00, calib[3]}, rd);
        master.i2c_msg(8'hec, 8'h50, 1, ack, rd);
        master.i2c_msg(8'hec, 8'h00, 1, ack, rd);
        master.i2c_msg(8'hed, 8'h00, 3, ack, rd);
        check("two-wire result", sensor.temperature, rd);
        $display("test two-wire done");
        final_report();
    end
endmodule
